// *** design/acb_defines.svh ***
// Constants for the AXI4-Lite to register clock-crossing bridge
`ifndef ACB_DEFINES_SVH
`define ACB_DEFINES_SVH
`define ACB_DATA_W 32
`define ACB_STRB_W 4
`define ACB_AXI_ADDR_W 18
`define ACB_WORD_ADDR_W 16
`define ACB_WORD_LSB 2
`define ACB_RESP_OKAY 2'h0
`define ACB_SYNC_RST 2'h0
`endif

// *** design/acb_pkg.sv ***
// Types shared by the bridge modules
package acb_pkg;
  typedef logic [31:0] acb_data_t;
  typedef logic [3:0] acb_strb_t;
  typedef logic [15:0] acb_waddr_t;
  typedef logic [17:0] acb_baddr_t;
  typedef enum logic [1:0] {
    ACB_IDLE = 2'b00,
    ACB_WR = 2'b01,
    ACB_RD = 2'b10,
    ACB_DONE = 2'b11
  } acb_state_t;
endpackage

// *** design/acb_level_sync.sv ***
// Two-flop synchroniser for a level
`include "acb_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module acb_level_sync (
  input wire logic clk,     // Destination clock
  input wire logic rst,     // Synchronous reset, active high
  input wire logic ce,      // Clock enable
  input wire logic din,     // Level from the other domain
  output logic dout         // Synchronised level
);
  logic [1:0] syncQ;
  // First stage feeds only the second
  always_ff @(posedge clk) begin
    if (rst) begin
      syncQ <= `ACB_SYNC_RST;
    end else if (ce) begin
      syncQ <= {syncQ[0], din};
    end
  end
  assign dout = syncQ[1];
endmodule
`default_nettype wire

// *** design/acb_user_port.sv ***
// User-domain side: turns crossed requests into register strobes
`include "acb_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module acb_user_port (
  input wire logic user_side_clock,             // User-side clock
  input wire logic userRst,             // Synchronous reset, user domain
  input wire logic userCe,              // Clock enable, user domain
  input wire logic reqTgl,              // Request toggle from CPU domain
  input wire logic reqIsWr,             // Request kind, stable while pending
  input wire acb_pkg::acb_waddr_t reqAddr, // Word address, stable while pending
  input wire acb_pkg::acb_data_t reqData,  // Write value, stable while pending
  input wire acb_pkg::acb_strb_t reqStrb,  // Byte lanes, stable while pending
  output logic ackTgl,                  // Completion toggle back to CPU domain
  output acb_pkg::acb_data_t rdValue,   // Captured read value, stable after ack
  output acb_pkg::acb_waddr_t regWordAddr, // Shared register word address
  output logic regWriteStrobe,          // One-cycle write strobe
  output acb_pkg::acb_data_t regWriteValue, // Write value
  output acb_pkg::acb_strb_t regByteLanes,  // Byte lane enables
  output logic regReadRequest,          // One-cycle read request
  input wire logic regReadValid,        // Read valid from slave
  input wire acb_pkg::acb_data_t regReadValue // Read data from slave
);
  import acb_pkg::*;
  logic reqSync;
  logic reqSeenQ;
  logic busyRdQ;
  logic ackQ;
  acb_data_t rdValueQ;
  acb_waddr_t addrQ;
  logic wrStbQ;
  acb_data_t wrValQ;
  acb_strb_t lanesQ;
  logic rdReqQ;
  logic newReq;

  acb_level_sync uReqSync (
    .clk(user_side_clock),
    .rst(userRst),
    .ce(userCe),
    .din(reqTgl),
    .dout(reqSync)
  );

  // Edge on the synchronised toggle marks a new access; payload is held stable upstream
  assign newReq = (reqSync != reqSeenQ);

  // Strobes and shared address; address holds through a read until valid
  always_ff @(posedge user_side_clock) begin
    if (userRst) begin
      reqSeenQ <= 1'b0;
      busyRdQ <= 1'b0;
      addrQ <= 16'h0000;
      wrStbQ <= 1'b0;
      wrValQ <= 32'h0000_0000;
      lanesQ <= 4'h0;
      rdReqQ <= 1'b0;
    end else if (userCe) begin
      wrStbQ <= 1'b0;
      rdReqQ <= 1'b0;
      if (newReq && !busyRdQ) begin
        reqSeenQ <= reqSync;
        addrQ <= reqAddr;
        if (reqIsWr) begin
          wrStbQ <= 1'b1;
          wrValQ <= reqData;
          lanesQ <= reqStrb;
        end else begin
          rdReqQ <= 1'b1;
          busyRdQ <= 1'b1;
        end
      end else if (busyRdQ && regReadValid) begin
        busyRdQ <= 1'b0;
      end
    end
  end

  // Completion: write acks after its strobe, read acks after valid with data
  always_ff @(posedge user_side_clock) begin
    if (userRst) begin
      ackQ <= 1'b0;
      rdValueQ <= 32'h0000_0000;
    end else if (userCe) begin
      if (wrStbQ) begin
        ackQ <= ~ackQ;
      end else if (busyRdQ && regReadValid) begin
        rdValueQ <= regReadValue;
        ackQ <= ~ackQ;
      end
    end
  end

  assign ackTgl = ackQ;
  assign rdValue = rdValueQ;
  assign regWordAddr = addrQ;
  assign regWriteStrobe = wrStbQ;
  assign regWriteValue = wrValQ;
  assign regByteLanes = lanesQ;
  assign regReadRequest = rdReqQ;
endmodule
`default_nettype wire

// *** design/acb_axi_lite_cdc_bridge.sv ***
// AXI4-Lite slave on the CPU clock bridged to a register port on the user clock
// How it works
// - Register port presents a 32-bit data path like the bus.
// - Bus logic on CPU clock, register port on user clock, toggle handshake between.
// - All five AXI4-Lite channels are terminated.
// - Write address, write data, read address and read data handled by separate logic.
// - Captured write address and data cross over to make a register write.
// - Captured read address crosses over to make a register read request.
// - Read data from the slave crosses back through registers.
// - One shared register address, loaded from write or read address.
// - Writes and reads are serialised, never issued together.
// - Write strobe pulses high with address, value and byte lanes.
// - Register address counts 32-bit words.
// - Four byte lane bits mark the four data bytes, low to high.
// - Read request pulses high with a valid address.
// - Address is held during a read until read valid.
// - Read latency is not fixed; the bridge waits for read valid.
// - After read valid the captured value goes out on the read data channel.
`include "acb_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module acb_axi_lite_cdc_bridge (
  input wire logic sys_clk,                   // CPU-side clock
  input wire logic rst,                       // Synchronous reset, CPU domain
  input wire logic ce,                        // Clock enable, CPU domain
  input wire logic s_axi_awvalid,             // Write address valid
  output logic s_axi_awready,                 // Write address ready
  input wire acb_pkg::acb_baddr_t s_axi_awaddr, // Write byte address
  input wire logic [2:0] s_axi_awprot,        // Write protection, ignored
  input wire logic s_axi_wvalid,              // Write data valid
  output logic s_axi_wready,                  // Write data ready
  input wire acb_pkg::acb_data_t s_axi_wdata, // Write data
  input wire acb_pkg::acb_strb_t s_axi_wstrb, // Write strobes
  output logic s_axi_bvalid,                  // Write response valid
  input wire logic s_axi_bready,              // Write response ready
  output logic [1:0] s_axi_bresp,             // Write response
  input wire logic s_axi_arvalid,             // Read address valid
  output logic s_axi_arready,                 // Read address ready
  input wire acb_pkg::acb_baddr_t s_axi_araddr, // Read byte address
  input wire logic [2:0] s_axi_arprot,        // Read protection, ignored
  output logic s_axi_rvalid,                  // Read data valid
  input wire logic s_axi_rready,              // Read data ready
  output acb_pkg::acb_data_t s_axi_rdata,     // Read data
  output logic [1:0] s_axi_rresp,             // Read response
  input wire logic user_side_clock,                   // User-side clock
  input wire logic userRst,                   // Synchronous reset, user domain
  input wire logic userCe,                    // Clock enable, user domain
  output acb_pkg::acb_waddr_t regWordAddr,    // Shared register word address
  output logic regWriteStrobe,                // Register write strobe
  output acb_pkg::acb_data_t regWriteValue,   // Register write value
  output acb_pkg::acb_strb_t regByteLanes,    // Register byte lane enables
  output logic regReadRequest,                // Register read request
  input wire logic regReadValid,              // Register read valid
  input wire acb_pkg::acb_data_t regReadValue // Register read value
);
  import acb_pkg::*;

  // Write address and write data slots, filled independently
  logic awHeldQ;
  acb_waddr_t awAddrQ;
  logic wHeldQ;
  acb_data_t wDataQ;
  acb_strb_t wStrbQ;

  // Read address slot
  logic arHeldQ;
  acb_waddr_t arAddrQ;

  // Arbiter state and the payload that rides across with the toggle
  acb_state_t stateQ;
  logic reqTglQ;
  logic reqIsWrQ;
  acb_waddr_t reqAddrQ;
  acb_data_t reqDataQ;
  acb_strb_t reqStrbQ;

  // Completion toggle after its two flops, and the copy last acted on
  logic ackSync;
  logic ackSeenQ;

  // Response channel registers
  logic bValidQ;
  logic [1:0] bRespQ;
  logic rValidQ;
  acb_data_t rDataQ;
  logic [1:0] rRespQ;

  // Ready flags, registered so that no bus output is combinational
  logic awReadyQ;
  logic wReadyQ;
  logic arReadyQ;

  // Links to the user-domain port
  acb_data_t rdValueX;
  logic ackTglX;

  // Decoded conditions
  logic ackEdge;
  logic wrPend;

  // A write may launch only once both of its halves have been taken
  assign wrPend = awHeldQ && wHeldQ;
  // A change of the synchronised toggle means the user side has finished
  assign ackEdge = (ackSync != ackSeenQ);

  // Write address ready drops for the cycle after a handshake and while the slot is full
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awReadyQ <= 1'b0;
    end else if (ce) begin
      awReadyQ <= !awHeldQ && !(s_axi_awvalid && awReadyQ);
    end
  end

  // Write data ready, same scheme as the address slot
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wReadyQ <= 1'b0;
    end else if (ce) begin
      wReadyQ <= !wHeldQ && !(s_axi_wvalid && wReadyQ);
    end
  end

  // Read address ready; a held read stalls further reads until it launches
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      arReadyQ <= 1'b0;
    end else if (ce) begin
      arReadyQ <= !arHeldQ && !(s_axi_arvalid && arReadyQ);
    end
  end

  // Write address logic; byte address becomes a word address
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      awHeldQ <= 1'b0;
      awAddrQ <= 16'h0000;
    end else if (ce) begin
      if (s_axi_awvalid && awReadyQ) begin
        awHeldQ <= 1'b1;
        awAddrQ <= s_axi_awaddr[`ACB_AXI_ADDR_W-1:`ACB_WORD_LSB];
      end else if (stateQ == ACB_IDLE && wrPend) begin
        awHeldQ <= 1'b0;
      end
    end
  end

  // Write data logic
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wHeldQ <= 1'b0;
      wDataQ <= 32'h0000_0000;
      wStrbQ <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && wReadyQ) begin
        wHeldQ <= 1'b1;
        wDataQ <= s_axi_wdata;
        wStrbQ <= s_axi_wstrb;
      end else if (stateQ == ACB_IDLE && wrPend) begin
        wHeldQ <= 1'b0;
      end
    end
  end

  // Read address logic
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      arHeldQ <= 1'b0;
      arAddrQ <= 16'h0000;
    end else if (ce) begin
      if (s_axi_arvalid && arReadyQ) begin
        arHeldQ <= 1'b1;
        arAddrQ <= s_axi_araddr[`ACB_AXI_ADDR_W-1:`ACB_WORD_LSB];
      end else if (stateQ == ACB_IDLE && !wrPend && arHeldQ) begin
        arHeldQ <= 1'b0;
      end
    end
  end

  // Arbiter: one access crosses at a time, write first; payload stays still until ack
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stateQ <= ACB_IDLE;
      reqTglQ <= 1'b0;
      reqIsWrQ <= 1'b0;
      reqAddrQ <= 16'h0000;
      reqDataQ <= 32'h0000_0000;
      reqStrbQ <= 4'h0;
      ackSeenQ <= 1'b0;
    end else if (ce) begin
      case (stateQ)
        ACB_IDLE: begin
          if (wrPend) begin
            reqIsWrQ <= 1'b1;
            reqAddrQ <= awAddrQ;
            reqDataQ <= wDataQ;
            reqStrbQ <= wStrbQ;
            reqTglQ <= ~reqTglQ;
            stateQ <= ACB_WR;
          end else if (arHeldQ) begin
            reqIsWrQ <= 1'b0;
            reqAddrQ <= arAddrQ;
            reqTglQ <= ~reqTglQ;
            stateQ <= ACB_RD;
          end
        end
        ACB_WR, ACB_RD: begin
          if (ackEdge) begin
            ackSeenQ <= ackSync;
            stateQ <= ACB_DONE;
          end
        end
        ACB_DONE: begin
          if ((bValidQ && s_axi_bready) || (rValidQ && s_axi_rready)) begin
            stateQ <= ACB_IDLE;
          end
        end
        default: begin
          stateQ <= ACB_IDLE;
        end
      endcase
    end
  end

  // Write response and read data channels
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bValidQ <= 1'b0;
      rValidQ <= 1'b0;
      rDataQ <= 32'h0000_0000;
    end else if (ce) begin
      if (ackEdge && stateQ == ACB_WR) begin
        bValidQ <= 1'b1;
      end else if (bValidQ && s_axi_bready) begin
        bValidQ <= 1'b0;
      end
      if (ackEdge && stateQ == ACB_RD) begin
        rValidQ <= 1'b1;
        rDataQ <= rdValueX;
      end else if (rValidQ && s_axi_rready) begin
        rValidQ <= 1'b0;
      end
    end
  end

  // Response codes leave flops like every other bus output; only OKAY is ever produced
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bRespQ <= `ACB_RESP_OKAY;
      rRespQ <= `ACB_RESP_OKAY;
    end else if (ce) begin
      if (ackEdge && stateQ == ACB_WR) begin
        bRespQ <= `ACB_RESP_OKAY;
      end
      if (ackEdge && stateQ == ACB_RD) begin
        rRespQ <= `ACB_RESP_OKAY;
      end
    end
  end

  // Completion toggle crosses back through two flops
  acb_level_sync uAckSync (
    .clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .din(ackTglX),
    .dout(ackSync)
  );

  // User-domain port; it reads the payload only after the toggle has settled
  acb_user_port uUser (
    .user_side_clock(user_side_clock),
    .userRst(userRst),
    .userCe(userCe),
    .reqTgl(reqTglQ),
    .reqIsWr(reqIsWrQ),
    .reqAddr(reqAddrQ),
    .reqData(reqDataQ),
    .reqStrb(reqStrbQ),
    .ackTgl(ackTglX),
    .rdValue(rdValueX),
    .regWordAddr(regWordAddr),
    .regWriteStrobe(regWriteStrobe),
    .regWriteValue(regWriteValue),
    .regByteLanes(regByteLanes),
    .regReadRequest(regReadRequest),
    .regReadValid(regReadValid),
    .regReadValue(regReadValue)
  );

  // Write side of the bus
  assign s_axi_awready = awReadyQ;
  assign s_axi_wready = wReadyQ;
  assign s_axi_bvalid = bValidQ;
  assign s_axi_bresp = bRespQ;

  // Read side of the bus
  assign s_axi_arready = arReadyQ;
  assign s_axi_rvalid = rValidQ;
  assign s_axi_rdata = rDataQ;
  assign s_axi_rresp = rRespQ;
endmodule
`default_nettype wire

// *** sim/acb_bridge_chk.sv ***
// Concurrent checks on the ports of the bridge top module
`timescale 1ns/1ps
`default_nettype none
module acb_bridge_chk (
  input wire logic sys_clk, // CPU clock
  input wire logic rst, // CPU reset
  input wire logic user_side_clock, // User clock
  input wire logic userRst, // User reset
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic s_axi_bvalid, // Response valid
  input wire logic s_axi_bready, // Response ready
  input wire logic [1:0] s_axi_bresp, // Response code
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire acb_pkg::acb_data_t s_axi_rdata, // Read data
  input wire acb_pkg::acb_waddr_t regWordAddr, // Register address
  input wire logic regWriteStrobe, // Write strobe
  input wire logic regReadRequest, // Read request
  input wire logic regReadValid // Read valid
);
  import acb_pkg::*;
  logic rdPendQ;
  // Read outstanding from request to valid; the address must not move then
  always_ff @(posedge user_side_clock) begin
    if (userRst)
      rdPendQ <= 1'h0;
    else if (regReadRequest)
      rdPendQ <= 1'h1;
    else if (regReadValid)
      rdPendQ <= 1'h0;
  end
  property p_noOverlap;
    @(posedge user_side_clock) disable iff (userRst) !(regWriteStrobe && regReadRequest);
  endproperty
  a_noOverlap: assert property (p_noOverlap) else $error("write and read together");
  property p_wrPulse;
    @(posedge user_side_clock) disable iff (userRst) regWriteStrobe |=> !regWriteStrobe;
  endproperty
  a_wrPulse: assert property (p_wrPulse) else $error("write strobe too long");
  property p_rdPulse;
    @(posedge user_side_clock) disable iff (userRst) regReadRequest ##1 1'h1 |-> !regReadRequest;
  endproperty
  a_rdPulse: assert property (p_rdPulse) else $error("read request too long");
  property p_addrHold;
    @(posedge user_side_clock) disable iff (userRst) rdPendQ |-> $stable(regWordAddr);
  endproperty
  a_addrHold: assert property (p_addrHold) else $error("address moved in read");
  property p_bOkay;
    @(posedge sys_clk) disable iff (rst) s_axi_bvalid |-> s_axi_bresp == 2'h0;
  endproperty
  a_bOkay: assert property (p_bOkay) else $error("write response not okay");
  property p_bHold;
    @(posedge sys_clk) disable iff (rst) s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bHold: assert property (p_bHold) else $error("write response dropped");
  property p_rHold;
    @(posedge sys_clk) disable iff (rst)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rHold: assert property (p_rHold) else $error("read data dropped");
  property p_awGap;
    @(posedge sys_clk) disable iff (rst) s_axi_awvalid && s_axi_awready |=> !s_axi_awready;
  endproperty
  a_awGap: assert property (p_awGap) else $error("address ready not lowered");
  property p_wGap;
    @(posedge sys_clk) disable iff (rst) s_axi_wvalid && s_axi_wready |=> !s_axi_wready;
  endproperty
  a_wGap: assert property (p_wGap) else $error("data ready not lowered");
endmodule
bind acb_axi_lite_cdc_bridge acb_bridge_chk u_chk (.sys_clk(sys_clk), .rst(rst),
  .user_side_clock(user_side_clock), .userRst(userRst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .regWordAddr(regWordAddr), .regWriteStrobe(regWriteStrobe),
  .regReadRequest(regReadRequest), .regReadValid(regReadValid));
`default_nettype wire

// *** sim/acb_reg_slave.sv ***
// Register file model standing on the user side of the bridge
`timescale 1ns/1ps
`default_nettype none
module acb_reg_slave (
  input wire logic user_side_clock, // User clock
  input wire logic userRst, // User reset
  input wire logic [3:0] latency, // Request to valid, at least 2
  input wire acb_pkg::acb_waddr_t regWordAddr, // Word address
  input wire logic regWriteStrobe, // Write strobe
  input wire acb_pkg::acb_data_t regWriteValue, // Write value
  input wire acb_pkg::acb_strb_t regByteLanes, // Byte lanes
  input wire logic regReadRequest, // Read request
  output logic regReadValid, // Read valid
  output acb_pkg::acb_data_t regReadValue, // Read value
  output acb_pkg::acb_waddr_t lastWrAddr // Address of last write
);
  import acb_pkg::*;
  acb_data_t memQ [16];
  logic [3:0] cntQ;
  // Byte-merged writes; only the low nibble decodes, so aliasing is expected
  always_ff @(posedge user_side_clock) begin
    if (userRst) begin
      for (int i = 0; i < 16; i++) memQ[i] <= 32'h0;
      lastWrAddr <= 16'h0;
    end else if (regWriteStrobe) begin
      for (int i = 0; i < 4; i++)
        if (regByteLanes[i]) memQ[regWordAddr[3:0]][8*i +: 8] <= regWriteValue[8*i +: 8];
      lastWrAddr <= regWordAddr;
    end
  end
  // Request delayed by the set latency; data is garbage outside the valid cycle
  always_ff @(posedge user_side_clock) begin
    if (userRst) begin
      cntQ <= 4'h0;
      regReadValid <= 1'h0;
      regReadValue <= 32'h0;
    end else begin
      if (regReadRequest)
        cntQ <= latency - 4'h1;
      else if (cntQ != 4'h0)
        cntQ <= cntQ - 4'h1;
      regReadValid <= (cntQ == 4'h1);
      regReadValue <= (cntQ == 4'h1) ? memQ[regWordAddr[3:0]] : ~regReadValue;
    end
  end
endmodule
`default_nettype wire

// *** sim/acb_axi_lite_cdc_bridge_test.sv ***
// Self-checking bench for the AXI4-Lite clock-crossing bridge
`timescale 1ns/1ps
`default_nettype none
module acb_axi_lite_cdc_bridge_test;
  import acb_pkg::*;
  logic sys_clk = 1'h0, user_side_clock = 1'h0, rst = 1'h1, userRst = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  acb_baddr_t s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
  acb_data_t s_axi_wdata = 32'h0;
  acb_strb_t s_axi_wstrb = 4'h0;
  logic [3:0] slaveLat = 4'h2;
  wire logic awready, wready, bvalid, arready, rvalid, wrStb, rdReq, rdValid;
  wire logic [1:0] bresp, rresp;
  wire acb_data_t rdata, wrValue, rdValue;
  wire acb_waddr_t wordAddr, lastWrAddr;
  wire acb_strb_t lanes;
  int mismatches = 0, comparisons = 0, cycles = 0;
  acb_axi_lite_cdc_bridge dut (.sys_clk(sys_clk), .rst(rst), .ce(1'h1),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(arready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .user_side_clock(user_side_clock), .userRst(userRst), .userCe(1'h1),
    .regWordAddr(wordAddr), .regWriteStrobe(wrStb), .regWriteValue(wrValue),
    .regByteLanes(lanes), .regReadRequest(rdReq), .regReadValid(rdValid),
    .regReadValue(rdValue));
  acb_reg_slave u_slave (.user_side_clock(user_side_clock), .userRst(userRst), .latency(slaveLat),
    .regWordAddr(wordAddr), .regWriteStrobe(wrStb), .regWriteValue(wrValue),
    .regByteLanes(lanes), .regReadRequest(rdReq), .regReadValid(rdValid),
    .regReadValue(rdValue), .lastWrAddr(lastWrAddr));
  // Clocks; the user clock gets an odd offset so edges never line up
  always #5 sys_clk = ~sys_clk;
  always begin
    #3.7;
    forever #15 user_side_clock = ~user_side_clock;
  end
  // Hang guard, sized well above the whole sequence
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Address and data travel on their own handshakes, data optionally late
  task automatic axi_write(input acb_baddr_t a, input acb_data_t d, input acb_strb_t s,
                           input int wDly, input int bStall);
    fork
      begin
        @(negedge sys_clk);
        s_axi_awaddr = a;
        s_axi_awvalid = 1'h1;
        do @(posedge sys_clk); while (awready !== 1'h1);
        @(negedge sys_clk);
        s_axi_awvalid = 1'h0;
      end
      begin
        repeat (wDly + 1) @(negedge sys_clk);
        s_axi_wdata = d;
        s_axi_wstrb = s;
        s_axi_wvalid = 1'h1;
        do @(posedge sys_clk); while (wready !== 1'h1);
        @(negedge sys_clk);
        s_axi_wvalid = 1'h0;
      end
    join
    do @(posedge sys_clk); while (bvalid !== 1'h1);
    repeat (bStall) @(posedge sys_clk);
    @(negedge sys_clk);
    s_axi_bready = 1'h1;
    @(posedge sys_clk);
    check("bvalid", {31'h0, bvalid}, 32'h1);
    check("bresp", {30'h0, bresp}, 32'h0);
    @(negedge sys_clk);
    s_axi_bready = 1'h0;
  endtask
  task automatic axi_read(input acb_baddr_t a, input int rStall, output acb_data_t d);
    @(negedge sys_clk);
    s_axi_araddr = a;
    s_axi_arvalid = 1'h1;
    do @(posedge sys_clk); while (arready !== 1'h1);
    @(negedge sys_clk);
    s_axi_arvalid = 1'h0;
    do @(posedge sys_clk); while (rvalid !== 1'h1);
    repeat (rStall) @(posedge sys_clk);
    @(negedge sys_clk);
    s_axi_rready = 1'h1;
    @(posedge sys_clk);
    d = rdata;
    check("rvalid", {31'h0, rvalid}, 32'h1);
    check("rresp", {30'h0, rresp}, 32'h0);
    @(negedge sys_clk);
    s_axi_rready = 1'h0;
  endtask
  // Words to spread addresses, then an unaligned top address
  task automatic t_basic;
    acb_data_t d;
    for (int i = 0; i < 4; i++) begin
      axi_write(18'(i * 32'h4404), 32'hA0B1C2D0 + i, 4'hF, i, 0);
      check("word address", {16'h0, lastWrAddr}, i * 32'h1101);
    end
    axi_write(18'h3FFFE, 32'h5EED0F0F, 4'hF, 0, 0);
    check("top word address", {16'h0, lastWrAddr}, 32'hFFFF);
    for (int i = 0; i < 4; i++) begin
      axi_read(18'(i * 32'h4404), 0, d);
      check("read back", d, 32'hA0B1C2D0 + i);
    end
    axi_read(18'h3FFFC, 0, d);
    check("top read back", d, 32'h5EED0F0F);
    $display("test basic done");
  endtask
  // One lane at a time into a cleared word
  task automatic t_lanes;
    acb_data_t d;
    acb_data_t exp;
    exp = 32'h0;
    axi_write(18'h20, 32'h0, 4'hF, 0, 0);
    for (int i = 0; i < 4; i++) begin
      axi_write(18'h20, 32'h8D6B4E29, 4'h1 << i, i, 0);
      exp[8*i +: 8] = 8'(32'h8D6B4E29 >> (8 * i));
      axi_read(18'h20, 0, d);
      check("lane merge", d, exp);
    end
    $display("test lanes done");
  endtask
  // Slow slave and a stalling master on both responses
  task automatic t_slow;
    acb_data_t d;
    slaveLat = 4'h9;
    axi_write(18'h24, 32'hC0FFEE11, 4'hF, 2, 3);
    axi_read(18'h24, 3, d);
    check("slow read", d, 32'hC0FFEE11);
    slaveLat = 4'h2;
    $display("test slow done");
  endtask
  // Write and read offered together on one word: the write goes first
  task automatic t_contend;
    acb_data_t d;
    axi_write(18'h14, 32'h11111111, 4'hF, 0, 0);
    fork
      axi_write(18'h14, 32'h2468ACE0, 4'hF, 0, 0);
      axi_read(18'h14, 0, d);
    join
    check("contended read", d, 32'h2468ACE0);
    $display("test contend done");
  endtask
  // Both resets overlap so the crossing starts even on each side
  initial begin
    fork
      begin
        repeat (2) @(negedge sys_clk);
        rst = 1'h0;
      end
      begin
        repeat (2) @(negedge user_side_clock);
        userRst = 1'h0;
      end
    join
    repeat (3) @(negedge sys_clk);
    t_basic();
    t_lanes();
    t_slow();
    t_contend();
    end_sim();
  end
endmodule
`default_nettype wire
